/* File: core/cbm_cycle_timer.sv */
// Purpose: down counter timing wait states and timeouts
// Assumes: load has priority over counting
// Notes:   expired is high while the count is zero

`timescale 1ns/100ps
`default_nettype none

module cbm_cycle_timer (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       load,
    input  wire logic [7:0] load_val,
    output logic            expired
);

    logic [7:0] cnt_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 8'h00;
        end else if (load) begin
            cnt_ff <= load_val;
        end else if (cnt_ff != 8'h00) begin
            cnt_ff <= cnt_ff - 8'h01;
        end
    end

    assign expired = (cnt_ff == 8'h00);

endmodule

`default_nettype wire

/* File: core/cbm_pkg.sv */
// Purpose: constants for the chip-select base and mode register block
// Assumes: 32-bit APB, one aligned word per register
// Notes:   register offsets are byte addresses
//
// Function
// (R1) base bits 15:7 hold address 23:15
// (R2) base bit 3 holds address bit 11
// (R3) base bits 6:4 and 2:0 read zero
// (R4) reset loads 0x0200 and 0x0600
// (R5) zero cs2 base extends cs1 to top
// (R6) zero cs1 base has no special meaning
// (R7) mode bits 15:14 select acknowledge mode
// (R8) mode holds wait count before strobe
// (R9) ack modes: ignore, timeout, no timeout, reserved
// (R10) timeout 255 cycles or strobe wait field
// (R11) writes to unimplemented bits leave nothing

package cbm_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0]  CS1_BASE_OFS  = 8'h00;
    localparam logic [7:0]  CS2_BASE_OFS  = 8'h04;
    localparam logic [7:0]  CS1_MODE_OFS  = 8'h08;
    localparam logic [7:0]  CS2_MODE_OFS  = 8'h0c;
    localparam logic [7:0]  CYCLE_CMD_OFS = 8'h10;
    localparam logic [7:0]  STATUS_OFS    = 8'h14;

    // ****************************************
    // field layout and reset values
    // ****************************************
    localparam logic [15:0] BASE_MASK     = 16'hff88;
    localparam logic [15:0] MODE_MASK     = 16'hf8ff;
    localparam logic [15:0] CS1_BASE_RST  = 16'h0200;
    localparam logic [15:0] CS2_BASE_RST  = 16'h0600;
    localparam logic [15:0] MODE_RST      = 16'h0000;
    localparam logic [23:0] LAST_ADDR     = 24'hffffff;
    localparam int          ACK_MSB       = 15;
    localparam int          ACK_LSB       = 14;
    localparam int          PRE_MSB       = 7;
    localparam int          PRE_LSB       = 6;
    localparam int          STB_MSB       = 5;
    localparam int          STB_LSB       = 2;
    localparam int          POST_MSB      = 1;
    localparam int          POST_LSB      = 0;

    // ****************************************
    // acknowledge modes and timing
    // ****************************************
    localparam logic [1:0]  ACK_IGNORE    = 2'h0;
    localparam logic [1:0]  ACK_TIMEOUT   = 2'h1;
    localparam logic [1:0]  ACK_WAIT      = 2'h2;
    localparam logic [7:0]  ACK_TMO_MAX   = 8'hff;

    typedef enum logic [2:0] {
        CBM_IDLE,
        CBM_PRE,
        CBM_STROBE,
        CBM_POST
    } cbm_state_t;

endpackage

/* File: core/cbm_top.sv */
// Purpose: chip-select base and mode registers with a strobe sequencer
// Assumes: APB slave on pclk, external ack arrives asynchronously
// Notes:   one access per command write, status shows busy and result

`timescale 1ns/100ps
`default_nettype none

module cbm_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        external_ack_input,
    output logic             cs1_select,
    output logic             cs2_select,
    output logic             strobe,
    output logic [23:0]      cs1_last_addr
);

    // ****************************************
    // declarations
    // ****************************************
    logic [15:0]         cs1_base_ff;
    logic [15:0]         cs2_base_ff;
    logic [15:0]         cs1_mode_ff;
    logic [15:0]         cs2_mode_ff;
    logic [31:0]         prdata_ff;
    logic                pready_ff;
    logic                pslverr_ff;
    logic                ack_meta_ff;
    logic                ack_sync_ff;
    logic [1:0]          stb_dly_ff;
    cbm_pkg::cbm_state_t state_ff;
    cbm_pkg::cbm_state_t nxt_state;
    logic                sel_cs2_ff;
    logic                done_ff;
    logic                timeout_ff;
    logic                cs1_sel_ff;
    logic                cs2_sel_ff;
    logic                strobe_ff;
    logic [23:0]         last_addr_ff;
    logic                wr_en;
    logic                rd_en;
    logic                mapped;
    logic                start;
    logic                cs2_off;
    logic [15:0]         mode;
    logic                tmr_load;
    logic [7:0]          tmr_val;
    logic                tmr_exp;
    logic                set_timeout;

    function automatic logic [31:0] widen(input logic [15:0] v);
        widen = {16'h0000, v};
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == cbm_pkg::CS1_BASE_OFS) ||
                    (a == cbm_pkg::CS2_BASE_OFS) ||
                    (a == cbm_pkg::CS1_MODE_OFS) ||
                    (a == cbm_pkg::CS2_MODE_OFS) ||
                    (a == cbm_pkg::CYCLE_CMD_OFS) ||
                    (a == cbm_pkg::STATUS_OFS);
    endfunction

    // ****************************************
    // apb decode
    // ****************************************
    assign mapped  = is_mapped(paddr);
    assign wr_en   = psel & penable & pwrite & ~pready_ff & mapped;
    assign rd_en   = psel & penable & ~pwrite & ~pready_ff;
    assign cs2_off = (cs2_base_ff == 16'h0000); // (R5)
    assign start   = wr_en & (paddr == cbm_pkg::CYCLE_CMD_OFS) &
                     pwdata[0] & (state_ff == cbm_pkg::CBM_IDLE) &
                     ~(pwdata[1] & cs2_off); // (R5)

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= psel & penable & ~pready_ff;
            pslverr_ff <= psel & penable & ~pready_ff & ~mapped;
        end
    end

    // ****************************************
    // configuration registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs1_base_ff <= cbm_pkg::CS1_BASE_RST; // (R4)
            cs2_base_ff <= cbm_pkg::CS2_BASE_RST; // (R4)
        end else if (wr_en) begin
            if (paddr == cbm_pkg::CS1_BASE_OFS) begin
                cs1_base_ff <= pwdata[15:0] & cbm_pkg::BASE_MASK; // (R1)
            end
            if (paddr == cbm_pkg::CS2_BASE_OFS) begin
                cs2_base_ff <= pwdata[15:0] & cbm_pkg::BASE_MASK; // (R2)
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs1_mode_ff <= cbm_pkg::MODE_RST;
            cs2_mode_ff <= cbm_pkg::MODE_RST;
        end else if (wr_en) begin
            if (paddr == cbm_pkg::CS1_MODE_OFS) begin
                cs1_mode_ff <= pwdata[15:0] & cbm_pkg::MODE_MASK; // (R11)
            end
            if (paddr == cbm_pkg::CS2_MODE_OFS) begin
                cs2_mode_ff <= pwdata[15:0] & cbm_pkg::MODE_MASK; // (R11)
            end
        end
    end

    // cs1 window ends below cs2 start, or at the top when cs2 is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_addr_ff <= 24'h000000;
        end else if (cs2_off) begin
            last_addr_ff <= cbm_pkg::LAST_ADDR; // (R5)
        end else begin
            last_addr_ff <= {cs2_base_ff[15:7], 3'h0, cs2_base_ff[3],
                             11'h000} - 24'h000001; // (R6)
        end
    end

    // ****************************************
    // read data
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
        end else if (rd_en) begin
            unique case (paddr)
                cbm_pkg::CS1_BASE_OFS:  prdata_ff <= widen(cs1_base_ff); // (R3)
                cbm_pkg::CS2_BASE_OFS:  prdata_ff <= widen(cs2_base_ff); // (R3)
                cbm_pkg::CS1_MODE_OFS:  prdata_ff <= widen(cs1_mode_ff);
                cbm_pkg::CS2_MODE_OFS:  prdata_ff <= widen(cs2_mode_ff);
                cbm_pkg::CYCLE_CMD_OFS: prdata_ff <= {31'h0, sel_cs2_ff};
                cbm_pkg::STATUS_OFS: begin
                    prdata_ff <= {28'h0, cs2_off, timeout_ff, done_ff,
                                  state_ff != cbm_pkg::CBM_IDLE};
                end
                default:                prdata_ff <= 32'h00000000;
            endcase
        end
    end

    // ****************************************
    // acknowledge synchroniser
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_meta_ff <= 1'b0;
            ack_sync_ff <= 1'b0;
            stb_dly_ff  <= 2'b00;
        end else begin
            ack_meta_ff <= external_ack_input;
            ack_sync_ff <= ack_meta_ff;
            stb_dly_ff  <= {stb_dly_ff[0], strobe_ff};
        end
    end

    // ****************************************
    // access sequencer
    // ****************************************
    assign mode = sel_cs2_ff ? cs2_mode_ff : cs1_mode_ff;
    always_comb begin
        nxt_state   = state_ff;
        tmr_load    = 1'b0;
        tmr_val     = 8'h00;
        set_timeout = 1'b0;
        unique case (state_ff)
            cbm_pkg::CBM_IDLE: begin
                if (start) begin
                    nxt_state = cbm_pkg::CBM_PRE;
                    tmr_load  = 1'b1;
                    tmr_val   = {6'h00, pwdata[1] ? // (R8)
                        cs2_mode_ff[cbm_pkg::PRE_MSB:cbm_pkg::PRE_LSB] :
                        cs1_mode_ff[cbm_pkg::PRE_MSB:cbm_pkg::PRE_LSB]};
                end
            end
            cbm_pkg::CBM_PRE: begin
                if (tmr_exp) begin // (R8)
                    nxt_state = cbm_pkg::CBM_STROBE;
                    tmr_load  = 1'b1;
                    tmr_val   = {4'h0,
                        mode[cbm_pkg::STB_MSB:cbm_pkg::STB_LSB]};
                    if ((mode[cbm_pkg::ACK_MSB:cbm_pkg::ACK_LSB] ==
                         cbm_pkg::ACK_TIMEOUT) && (tmr_val == 8'h00)) begin
                        tmr_val = cbm_pkg::ACK_TMO_MAX; // (R10)
                    end
                end
            end
            cbm_pkg::CBM_STROBE: begin
                unique case (mode[cbm_pkg::ACK_MSB:cbm_pkg::ACK_LSB]) // (R7)
                    cbm_pkg::ACK_TIMEOUT: begin
                        if (ack_sync_ff & stb_dly_ff[1]) begin // (R9)
                            nxt_state = cbm_pkg::CBM_POST;
                        end else if (tmr_exp) begin
                            nxt_state   = cbm_pkg::CBM_POST;
                            set_timeout = 1'b1; // (R10)
                        end
                    end
                    cbm_pkg::ACK_WAIT: begin
                        if (ack_sync_ff & stb_dly_ff[1]) begin // (R9)
                            nxt_state = cbm_pkg::CBM_POST;
                        end
                    end
                    default: begin
                        if (tmr_exp) begin // (R9)
                            nxt_state = cbm_pkg::CBM_POST;
                        end
                    end
                endcase
                if (nxt_state == cbm_pkg::CBM_POST) begin
                    tmr_load = 1'b1;
                    tmr_val  = {6'h00,
                        mode[cbm_pkg::POST_MSB:cbm_pkg::POST_LSB]};
                end
            end
            cbm_pkg::CBM_POST: begin
                if (tmr_exp) begin
                    nxt_state = cbm_pkg::CBM_IDLE;
                end
            end
            default: nxt_state = cbm_pkg::CBM_IDLE;
        endcase
    end
    cbm_cycle_timer u_timer (
        .pclk     (pclk),
        .presetn  (presetn),
        .load     (tmr_load),
        .load_val (tmr_val),
        .expired  (tmr_exp)
    );
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff   <= cbm_pkg::CBM_IDLE;
            sel_cs2_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (start) begin
                sel_cs2_ff <= pwdata[1];
            end
        end
    end

    // result flags clear at the start of the next access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_ff    <= 1'b0;
            timeout_ff <= 1'b0;
        end else if (start) begin
            done_ff    <= 1'b0;
            timeout_ff <= 1'b0;
        end else begin
            if ((state_ff == cbm_pkg::CBM_POST) && tmr_exp) begin
                done_ff <= 1'b1;
            end
            if (set_timeout) begin
                timeout_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs1_sel_ff <= 1'b0;
            cs2_sel_ff <= 1'b0;
            strobe_ff  <= 1'b0;
        end else begin
            cs1_sel_ff <= (nxt_state != cbm_pkg::CBM_IDLE) &
                          ~(start ? pwdata[1] : sel_cs2_ff);
            cs2_sel_ff <= (nxt_state != cbm_pkg::CBM_IDLE) &
                          (start ? pwdata[1] : sel_cs2_ff);
            strobe_ff  <= (nxt_state == cbm_pkg::CBM_STROBE);
        end
    end

    assign prdata        = prdata_ff;
    assign pready        = pready_ff;
    assign pslverr       = pslverr_ff;
    assign cs1_select    = cs1_sel_ff;
    assign cs2_select    = cs2_sel_ff;
    assign strobe        = strobe_ff;
    assign cs1_last_addr = last_addr_ff;

endmodule

`default_nettype wire

/* File: verif/cbm_ack_model.sv */
// Purpose: external peripheral answering strobes with an acknowledge
// Assumes: ack raised a set number of strobe cycles after it starts
// Notes:   en low models a device that never answers
`timescale 1ns/100ps
`default_nettype none
module cbm_ack_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       cs_any,
    input  wire logic       strobe,
    input  wire logic       en,
    input  wire logic [7:0] dly,
    output logic            ack
);
    logic [7:0] cnt_ff;
    logic       idle_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cnt_ff <= 8'h0;
        else if (!strobe) cnt_ff <= 8'h0;
        else if (cnt_ff != 8'hff) cnt_ff <= cnt_ff + 8'h1;
    end
    // a released line shows the inverse of its last driven level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) idle_ff <= 1'h0;
        else if (cs_any) idle_ff <= !ack;
    end
    assign ack = cs_any ? (en && strobe && cnt_ff >= dly) : idle_ff;
endmodule
`default_nettype wire

/* File: verif/cbm_checker.sv */
// Purpose: port assertions for the chip-select register block
// Assumes: sees only the ports of cbm_top
// Notes:   bound from tb_top
`timescale 1ns/100ps
`default_nettype none
module cbm_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        external_ack_input,
    input wire logic        cs1_select,
    input wire logic        cs2_select,
    input wire logic        strobe,
    input wire logic [23:0] cs1_last_addr
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic take = psel && penable && !pready;
    wire logic wr0  = take && pwrite && pwdata[15:0] == 16'h0;
    wire logic rdb  = pready && !pwrite && paddr[7:3] == 5'h0;
    ready_in_time_a: assert property (take |=> pready)
        else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    error_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    base_zero_bits_a: assert property (
        rdb |-> (prdata & 32'hffff0077) == 32'h0)
        else $error("unimplemented base bits read nonzero");
    reset_last_addr_a: assert property (
        $rose(presetn) |-> ##[1:2] cs1_last_addr == 24'h05ffff)
        else $error("last address wrong after reset");
    window_extend_a: assert property (
        wr0 && paddr == cbm_pkg::CS2_BASE_OFS
        |-> ##[1:3] cs1_last_addr == cbm_pkg::LAST_ADDR)
        else $error("zero second base did not extend first window");
    no_extend_a: assert property (
        wr0 && paddr == cbm_pkg::CS1_BASE_OFS
        |=> $stable(cs1_last_addr)[*2])
        else $error("zero first base moved the window end");
    strobe_in_select_a: assert property (
        strobe |-> cs1_select || cs2_select)
        else $error("strobe without chip select");
    strobe_after_wait_a: assert property (
        $rose(strobe) |-> $past(cs1_select) || $past(cs2_select))
        else $error("strobe without preceding select cycle");
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// Purpose: self-checking bench for the chip-select register block
// Assumes: APB master here, ack device model on the far side
// Notes:   random data from a fixed seed plus corner cases
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, ack, ack_en, err;
    logic        pready, pslverr, cs1_select, cs2_select, strobe;
    logic [7:0]  paddr, ack_dly;
    logic [31:0] pwdata, prdata, rd;
    logic [23:0] cs1_last_addr;
    logic [15:0] v, cs2_base;
    logic [3:0]  s;
    int          fails, comparisons, stb_n, cs2_n, cs1_n, c;
    logic [7:0]  ofs [4] = '{8'h00, 8'h04, 8'h08, 8'h0c};
    logic [15:0] rst [4] = '{16'h0200, 16'h0600, 16'h0, 16'h0};
    logic [15:0] msk [4] = '{16'hff88, 16'hff88, 16'hf8ff, 16'hf8ff};
    localparam logic [7:0] ST = cbm_pkg::STATUS_OFS;
    cbm_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_ack_input(ack), .cs1_select(cs1_select),
        .cs2_select(cs2_select), .strobe(strobe),
        .cs1_last_addr(cs1_last_addr));
    cbm_ack_model i_dev (.pclk(pclk), .presetn(presetn),
        .cs_any(cs1_select || cs2_select), .strobe(strobe), .en(ack_en),
        .dly(ack_dly), .ack(ack));
    initial begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (strobe === 1'h1) stb_n <= stb_n + 1;
        if (cs2_select === 1'h1) cs2_n <= cs2_n + 1;
        if (cs1_select === 1'h1) cs1_n <= cs1_n + 1;
    end
    // ****************************************
    // checking and bus tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [15:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0, d};
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            fails++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    function automatic logic [23:0] last_of(input logic [15:0] b);
        return (b == 16'h0) ? 24'hffffff :
               {b[15:7], 3'h0, b[3], 11'h0} - 24'h1;
    endfunction
    function automatic logic [15:0] md(input logic [1:0] k,
                                       input logic [1:0] p,
                                       input logic [3:0] w);
        return {k, 3'h5, 3'h0, p, w, 2'h1};
    endfunction
    task automatic run(input logic [15:0] m, input logic c2, input int lo,
                       input int hi, input logic [3:0] st);
        int s0, n, c1;
        s0 = stb_n;
        c = cs2_n;
        c1 = cs1_n;
        apb(1'h1, c2 ? cbm_pkg::CS2_MODE_OFS : cbm_pkg::CS1_MODE_OFS, m);
        apb(1'h1, cbm_pkg::CYCLE_CMD_OFS, {14'h0, c2, 1'h1});
        n = 0;
        do begin
            apb(1'h0, ST, 16'h0);
            n++;
        end while (rd[1] !== 1'h1 && n < 150);
        if (rd[1] !== 1'h1) begin
            fails++;
            final_report();
        end
        chk({31'h0, stb_n - s0 >= lo && stb_n - s0 <= hi}, 32'h1);
        chk(rd & 32'hf, {28'h0, st});
        chk({31'h0, cs2_n > c}, {31'h0, c2});
        chk({31'h0, cs1_n > c1}, {31'h0, !c2});
        apb(1'h0, cbm_pkg::CYCLE_CMD_OFS, 16'h0);
        chk(rd, {31'h0, c2});
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {presetn, psel, penable, pwrite, ack_en} = 5'h0;
        {paddr, ack_dly, pwdata} = 48'h0;
        {fails, comparisons, stb_n, cs2_n, cs1_n} = 160'h0;
        void'($urandom(32'h855a));
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        foreach (ofs[i]) begin
            apb(1'h0, ofs[i], 16'h0);
            chk(rd, {16'h0, rst[i]});
        end
        repeat (8) foreach (ofs[i]) begin
            v = 16'($urandom);
            if (i == 1) v[15] = 1'h1;
            if (i == 1) cs2_base = v;
            apb(1'h1, ofs[i], v);
            apb(1'h0, ofs[i], 16'h0);
            chk(rd, {16'h0, v & msk[i]});
        end
        chk({8'h0, cs1_last_addr}, {8'h0, last_of(cs2_base)});
        apb(1'h1, ofs[0], 16'h0);
        apb(1'h0, ofs[0], 16'h0);
        chk({8'h0, cs1_last_addr}, {8'h0, last_of(cs2_base)});
        s = 4'($urandom_range(15, 1));
        run(md(2'h0, 2'($urandom), s), 1'h0, s + 1, s + 1, 4'h2);
        run(md(2'h3, 2'($urandom), s), 1'h1, s + 1, s + 1, 4'h2);
        run(md(2'h1, 2'h3, s), 1'h0, s, s + 3, 4'h6);
        run(md(2'h1, 2'h3, 4'h0), 1'h1, 255, 258, 4'h6);
        // idle ack line is high here: no pre wait must not end early
        run(md(2'h1, 2'h0, 4'h4), 1'h0, 4, 7, 4'h6);
        ack_en <= 1'h1;
        ack_dly <= 8'h5;
        run(md(2'h2, 2'h3, 4'h0), 1'h0, 6, 10, 4'h2);
        ack_dly <= 8'h2;
        run(md(2'h1, 2'h3, 4'hf), 1'h0, 3, 7, 4'h2);
        apb(1'h0, 8'h18, 16'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'h1, ofs[1], 16'h0);
        apb(1'h0, ST, 16'h0);
        chk(rd & 32'h8, 32'h8);
        chk({8'h0, cs1_last_addr}, 32'hffffff);
        apb(1'h1, cbm_pkg::CYCLE_CMD_OFS, 16'h3);
        apb(1'h0, ST, 16'h0);
        chk(rd & 32'h1, 32'h0);
        chk(cs2_n, c);
        final_report();
    end
endmodule
bind cbm_top cbm_checker i_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_ack_input(external_ack_input), .cs1_select(cs1_select),
    .cs2_select(cs2_select), .strobe(strobe),
    .cs1_last_addr(cs1_last_addr));
`default_nettype wire
